// file: hdl/bpc_params.svh
// Constants for the block protection command controller
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

`define BPC_ADDR_W 23
`define BPC_CLK_NS 8
// Flash bus timing, in ns, and derived cycle counts (rounded up)
`define BPC_T_WP_NS 35
`define BPC_T_ACC_NS 70
`define BPC_T_UNLOCK_GAP_NS 1000
`define BPC_WP_CYC ((`BPC_T_WP_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_ACC_CYC ((`BPC_T_ACC_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_GAP_CYC ((`BPC_T_UNLOCK_GAP_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)

// Software register offsets
`define BPC_REG_CTRL 8'h00
`define BPC_REG_ADDR 8'h04
`define BPC_REG_DATA 8'h08
`define BPC_REG_RDATA 8'h0C
`define BPC_REG_PWD0 8'h10

// Control/status fields
`define BPC_CTRL_OP_LSB 0
`define BPC_STAT_BUSY 0
`define BPC_STAT_DONE 1
`define BPC_STAT_ERR 2
`define BPC_STAT_ACTIVE 3
`define BPC_STAT_SET_LSB 8

// Flash cycle addresses and codes
`define BPC_UNLOCK_ADDR1 23'h000555
`define BPC_UNLOCK_ADDR2 23'h0002AA
`define BPC_UNLOCK_DATA1 16'h00AA
`define BPC_UNLOCK_DATA2 16'h0055
`define BPC_CODE_NV 8'hC0
`define BPC_CODE_VOL 8'hE0
`define BPC_CODE_PWD 8'h60
`define BPC_CMD_EXIT1 16'h0090
`define BPC_CMD_EXIT2 16'h0000
`define BPC_CMD_PROG 16'h00A0
`define BPC_CMD_CLR1 16'h0080
`define BPC_CMD_CLR2 16'h0030
`define BPC_CMD_UNL1 16'h0025
`define BPC_CMD_UNL2 16'h0003
`define BPC_CMD_UNL_END 16'h0029

// Reset values
`define BPC_RST_ADDR 23'h000000
`define BPC_RST_DATA 16'h0000
`define BPC_RST_PWD 16'hFFFF
`endif

// file: hdl/bpc_pkg.sv
// Types for the block protection command controller
package bpc_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SETUP = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD = 5'h08,
        ST_GAP = 5'h10
    } bpc_fsm_t;

    typedef enum logic [2:0] {
        OP_ENTER = 3'h0,
        OP_EXIT = 3'h1,
        OP_PROG = 3'h2,
        OP_READ = 3'h3,
        OP_CLRNV = 3'h4,
        OP_UNLOCK = 3'h5
    } bpc_op_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [22:0] addr;
        logic [15:0] dq_o;
        logic dq_oe;
    } bpc_pins_t;

    typedef struct packed {
        bpc_fsm_t fsm;
        bpc_op_t op;
        logic [2:0] step;
        logic [7:0] cnt;
        bpc_pins_t pins;
        logic [22:0] cfg_addr;
        logic [15:0] cfg_data;
        logic [3:0][15:0] pwd;
        logic [15:0] rdata;
        logic [31:0] sw_rdata;
        logic busy;
        logic done;
        logic err;
        logic set_active;
        logic [7:0] set_code;
    } bpc_state_t;
endpackage

// file: hdl/bpc_host.sv
// Host-side controller issuing block protection command sequences to a x16 flash
//
// Functional notes
// - Enter set: 555/AA, 2AA/55, 555/set code.
// - Leave set with 90 then 00 at any address.
// - Lock register program: A0, then data at address 00.
// - Password program: A0 then one portion at its address, repeated per portion.
// - Password is four words at addresses 00 to 03, any order.
// - Unlock: 00/25, 00/03, four portions from 00, then 00/29.
// - Nonvolatile protect: A0, then 00 inside target block.
// - Clear all nonvolatile bits: 80 then 30 at address 00.
// - Lock bit program: A0 then 00, don't-care addresses.
// - Volatile bit: A0 then 00 sets, 01 clears, inside block.
// - Nonvolatile and volatile entry carry bank address with 555.
// - Extended block: plain reads; program with A0 then data at target.
// - Register, password and status reads are read cycles, not writes.
// - Successive unlocks need a gap of about one microsecond.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`include "bpc_params.svh"

module bpc_host (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] sw_addr, // Register byte address
    input wire logic [31:0] sw_wdata, // Register write data
    input wire logic sw_wr, // Register write strobe
    input wire logic sw_rd, // Register read strobe
    output logic [31:0] sw_rdata, // Register read data, cycle after strobe
    output bpc_pkg::bpc_pins_t flash_pins, // Flash control, address, data out, enable
    input wire logic [15:0] flash_dq_i // Flash data in
);
    localparam logic [7:0] WP_CYC = 8'(`BPC_WP_CYC);
    localparam logic [7:0] ACC_CYC = 8'(`BPC_ACC_CYC);
    localparam logic [7:0] GAP_CYC = 8'(`BPC_GAP_CYC);

    bpc_pkg::bpc_state_t s_reg;
    bpc_pkg::bpc_state_t s_next;

    // Current cycle of the active sequence
    logic [22:0] cyc_addr;
    logic [15:0] cyc_data;
    logic cyc_read;
    logic cyc_last;
    logic [7:0] code;
    logic [1:0] pidx;

    assign code = s_reg.cfg_data[7:0];
    assign pidx = 2'(s_reg.step - 3'h2);

    always_comb begin
        cyc_addr = `BPC_RST_ADDR;
        cyc_data = `BPC_RST_DATA;
        cyc_read = 1'b0;
        cyc_last = 1'b0;
        case (s_reg.op)
            bpc_pkg::OP_ENTER: begin
                case (s_reg.step)
                    3'h0: begin
                        cyc_addr = `BPC_UNLOCK_ADDR1;
                        cyc_data = `BPC_UNLOCK_DATA1;
                    end
                    3'h1: begin
                        cyc_addr = `BPC_UNLOCK_ADDR2;
                        cyc_data = `BPC_UNLOCK_DATA2;
                    end
                    default: begin
                        if (code == `BPC_CODE_NV || code == `BPC_CODE_VOL) begin
                            cyc_addr = s_reg.cfg_addr | `BPC_UNLOCK_ADDR1;
                        end else begin
                            cyc_addr = `BPC_UNLOCK_ADDR1;
                        end
                        cyc_data = {8'h00, code};
                        cyc_last = 1'b1;
                    end
                endcase
            end
            bpc_pkg::OP_EXIT: begin
                cyc_data = (s_reg.step == 3'h0) ? `BPC_CMD_EXIT1 : `BPC_CMD_EXIT2;
                cyc_last = (s_reg.step != 3'h0);
            end
            bpc_pkg::OP_PROG: begin
                if (s_reg.step == 3'h0) begin
                    cyc_data = `BPC_CMD_PROG;
                end else begin
                    cyc_addr = s_reg.cfg_addr;
                    cyc_data = s_reg.cfg_data;
                    cyc_last = 1'b1;
                end
            end
            bpc_pkg::OP_READ: begin
                cyc_addr = s_reg.cfg_addr;
                cyc_read = 1'b1;
                cyc_last = 1'b1;
            end
            bpc_pkg::OP_CLRNV: begin
                // 80 then 30 at address 00
                cyc_data = (s_reg.step == 3'h0) ? `BPC_CMD_CLR1 : `BPC_CMD_CLR2;
                cyc_last = (s_reg.step != 3'h0);
            end
            bpc_pkg::OP_UNLOCK: begin
                case (s_reg.step)
                    3'h0: cyc_data = `BPC_CMD_UNL1;
                    3'h1: cyc_data = `BPC_CMD_UNL2;
                    3'h6: begin
                        cyc_data = `BPC_CMD_UNL_END;
                        cyc_last = 1'b1;
                    end
                    default: begin
                        cyc_addr = {21'h000000, pidx};
                        cyc_data = s_reg.pwd[pidx];
                    end
                endcase
            end
            default: begin
                cyc_last = 1'b1;
            end
        endcase
    end

    always_comb begin
        s_next = s_reg;
        // Software register access
        if (sw_wr && !s_reg.busy) begin
            case (sw_addr)
                `BPC_REG_ADDR: s_next.cfg_addr = sw_wdata[22:0];
                `BPC_REG_DATA: s_next.cfg_data = sw_wdata[15:0];
                default: ;
            endcase
            for (int i = 0; i < 4; i++) begin
                if (sw_addr == 8'(`BPC_REG_PWD0 + 4 * i)) begin
                    s_next.pwd[i] = sw_wdata[15:0];
                end
            end
        end
        if (sw_rd) begin
            s_next.sw_rdata = 32'h00000000;
            case (sw_addr)
                `BPC_REG_CTRL: begin
                    s_next.sw_rdata[`BPC_STAT_BUSY] = s_reg.busy;
                    s_next.sw_rdata[`BPC_STAT_DONE] = s_reg.done;
                    s_next.sw_rdata[`BPC_STAT_ERR] = s_reg.err;
                    s_next.sw_rdata[`BPC_STAT_ACTIVE] = s_reg.set_active;
                    s_next.sw_rdata[`BPC_STAT_SET_LSB +: 8] = s_reg.set_code;
                end
                `BPC_REG_ADDR: s_next.sw_rdata[22:0] = s_reg.cfg_addr;
                `BPC_REG_DATA: s_next.sw_rdata[15:0] = s_reg.cfg_data;
                `BPC_REG_RDATA: s_next.sw_rdata[15:0] = s_reg.rdata;
                default: ;
            endcase
            for (int i = 0; i < 4; i++) begin
                if (sw_addr == 8'(`BPC_REG_PWD0 + 4 * i)) begin
                    s_next.sw_rdata[15:0] = s_reg.pwd[i];
                end
            end
        end

        case (s_reg.fsm)
            bpc_pkg::ST_IDLE: begin
                if (sw_wr && sw_addr == `BPC_REG_CTRL) begin
                    s_next.done = 1'b0;
                    s_next.err = 1'b0;
                    s_next.op = bpc_pkg::bpc_op_t'(sw_wdata[`BPC_CTRL_OP_LSB +: 3]);
                    s_next.step = 3'h0;
                    // only sequences legal in the active set are issued
                    case (bpc_pkg::bpc_op_t'(sw_wdata[`BPC_CTRL_OP_LSB +: 3]))
                        bpc_pkg::OP_ENTER: s_next.err = s_reg.set_active;
                        bpc_pkg::OP_EXIT: s_next.err = !s_reg.set_active;
                        bpc_pkg::OP_PROG: s_next.err = !s_reg.set_active;
                        bpc_pkg::OP_READ: s_next.err = 1'b0;
                        bpc_pkg::OP_CLRNV: begin
                            s_next.err = s_reg.set_code != `BPC_CODE_NV || !s_reg.set_active;
                        end
                        bpc_pkg::OP_UNLOCK: begin
                            s_next.err = s_reg.set_code != `BPC_CODE_PWD || !s_reg.set_active;
                        end
                        default: s_next.err = 1'b1;
                    endcase
                    if (s_next.err) begin
                        s_next.done = 1'b1;
                    end else begin
                        s_next.busy = 1'b1;
                        s_next.fsm = bpc_pkg::ST_SETUP;
                    end
                end
            end
            bpc_pkg::ST_SETUP: begin
                s_next.pins.ce_n = 1'b0;
                s_next.pins.addr = cyc_addr;
                s_next.pins.dq_o = cyc_data;
                s_next.pins.dq_oe = !cyc_read;
                s_next.cnt = cyc_read ? ACC_CYC : WP_CYC;
                s_next.fsm = bpc_pkg::ST_STROBE;
            end
            bpc_pkg::ST_STROBE: begin
                s_next.pins.we_n = cyc_read;
                s_next.pins.oe_n = !cyc_read;
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h00) begin
                    s_next.pins.we_n = 1'b1;
                    s_next.pins.oe_n = 1'b1;
                    if (cyc_read) begin
                        s_next.rdata = flash_dq_i;
                    end
                    s_next.fsm = bpc_pkg::ST_HOLD;
                end
            end
            bpc_pkg::ST_HOLD: begin
                s_next.pins.ce_n = 1'b1;
                s_next.pins.dq_oe = 1'b0;
                s_next.step = s_reg.step + 3'h1;
                if (!cyc_last) begin
                    s_next.fsm = bpc_pkg::ST_SETUP;
                end else if (s_reg.op == bpc_pkg::OP_UNLOCK) begin
                    // hold off before another unlock may start
                    s_next.cnt = GAP_CYC;
                    s_next.fsm = bpc_pkg::ST_GAP;
                end else begin
                    if (s_reg.op == bpc_pkg::OP_ENTER) begin
                        s_next.set_active = 1'b1;
                        s_next.set_code = code;
                    end
                    if (s_reg.op == bpc_pkg::OP_EXIT) begin
                        s_next.set_active = 1'b0;
                        s_next.set_code = 8'h00;
                    end
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.fsm = bpc_pkg::ST_IDLE;
                end
            end
            bpc_pkg::ST_GAP: begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h00) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.fsm = bpc_pkg::ST_IDLE;
                end
            end
            default: begin
                s_next.fsm = bpc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg.fsm <= bpc_pkg::ST_IDLE;
            s_reg.op <= bpc_pkg::OP_READ;
            s_reg.step <= 3'h0;
            s_reg.cnt <= 8'h00;
            s_reg.pins.ce_n <= 1'b1;
            s_reg.pins.oe_n <= 1'b1;
            s_reg.pins.we_n <= 1'b1;
            s_reg.pins.addr <= `BPC_RST_ADDR;
            s_reg.pins.dq_o <= `BPC_RST_DATA;
            s_reg.pins.dq_oe <= 1'b0;
            s_reg.cfg_addr <= `BPC_RST_ADDR;
            s_reg.cfg_data <= `BPC_RST_DATA;
            s_reg.pwd <= {4{`BPC_RST_PWD}};
            s_reg.rdata <= `BPC_RST_DATA;
            s_reg.sw_rdata <= 32'h00000000;
            s_reg.busy <= 1'b0;
            s_reg.done <= 1'b0;
            s_reg.err <= 1'b0;
            s_reg.set_active <= 1'b0;
            s_reg.set_code <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sw_rdata = s_reg.sw_rdata;
    assign flash_pins = s_reg.pins;
endmodule

// file: test/bpc_host_properties.sv
// Port assertions for the block protection controller
module bpc_host_properties (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [7:0] sw_addr, // Register address
    input wire logic [31:0] sw_wdata, // Register write data
    input wire logic sw_wr, // Write strobe
    input wire logic sw_rd, // Read strobe
    input wire logic [31:0] sw_rdata, // Register read data
    input wire bpc_pkg::bpc_pins_t flash_pins, // Flash pins
    input wire logic [15:0] flash_dq_i // Flash data in
);
    // Counts sampled cycles with the read strobe low
    logic [7:0] oe_low_cnt;
    always_ff @(posedge clk_sys) begin
        if (rst || flash_pins.oe_n) begin
            oe_low_cnt <= 8'h00;
        end else begin
            oe_low_cnt <= oe_low_cnt + 8'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_no_dual_strobe: assert property (
        !(!flash_pins.we_n && !flash_pins.oe_n)) else $error("both strobes low");
    a_read_strobe_len: assert property (
        $rose(flash_pins.oe_n) |-> oe_low_cnt == 8'h09)
        else $error("read strobe length");
    a_write_strobe_len: assert property (
        $fell(flash_pins.we_n) |-> (!flash_pins.we_n)[*5] ##1 flash_pins.we_n)
        else $error("write strobe length");
    a_strobe_needs_ce: assert property (
        (!flash_pins.we_n || !flash_pins.oe_n) |-> !flash_pins.ce_n) else $error("strobe without ce");
    a_setup_before_we: assert property (
        $fell(flash_pins.we_n) |-> $past(flash_pins.ce_n) == 1'b0) else $error("no setup cycle");
    a_write_stable: assert property (
        (!flash_pins.we_n && $past(flash_pins.we_n) == 1'b0)
        |-> $stable(flash_pins.addr) && $stable(flash_pins.dq_o)) else $error("write data moved");
    a_read_no_drive: assert property (
        !flash_pins.oe_n |-> !flash_pins.dq_oe) else $error("driving during read");
    a_release_ce: assert property (
        $rose(flash_pins.we_n) |-> !flash_pins.ce_n ##1 flash_pins.ce_n) else $error("ce not released");
endmodule

// file: test/bpc_flash_model.sv
// Behavioural x16 flash answering protection command sequences
module bpc_flash_model #(
    parameter int BLK_LSB = 16
) (
    input wire logic clk_sys, // System clock
    input wire bpc_pkg::bpc_pins_t pins, // Controller pins
    output logic [15:0] dq // Data towards the controller
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] set_code = 8'h00;
    logic [15:0] lock_reg = 16'hFFFF;
    logic [15:0] pwd [4] = '{default: 16'hFFFF};
    logic [127:0] nv_prot = '0;
    logic [127:0] vol_prot = '0;
    logic lock_bit = 1'b1;
    logic prev_we = 1'b1;
    logic ok = 1'b0;
    logic [15:0] last = 16'h0000;
    int stp = 0;
    function automatic logic [15:0] rval(input logic [22:0] a);
        case (set_code)
            8'hC0: rval = {15'h0000, ~nv_prot[7'(a >> BLK_LSB)]};
            8'hE0: rval = {15'h0000, ~vol_prot[7'(a >> BLK_LSB)]};
            8'h50: rval = {15'h0000, lock_bit};
            8'h40: rval = lock_reg;
            8'h60: rval = pwd[a[1:0]];
            default: rval = a[15:0] ^ 16'h5A5A;
        endcase
    endfunction
    // commands decoded from the low byte only
    task automatic wcyc(input logic [22:0] a, input logic [15:0] w);
        logic [7:0] c;
        logic [6:0] b;
        int s0;
        s0 = stp;
        c = w[7:0];
        b = 7'(a >> BLK_LSB);
        case (stp)
            0: stp = (set_code == 8'h00) ? ((a[10:0] == 11'h555 && c == 8'hAA) ? 1 : 0)
                : (c == 8'h90) ? 5 : (c == 8'hA0) ? 6 : (c == 8'h80) ? 7 : (c == 8'h25) ? 8 : 0;
            1: stp = (a[10:0] == 11'h2AA && c == 8'h55) ? 2 : 0;
            2: set_code = (a[10:0] == 11'h555) ? c : set_code;
            5: set_code = (c == 8'h00) ? 8'h00 : set_code;
            6: case (set_code)
                8'h40: lock_reg = w;
                8'h60: pwd[a[1:0]] = w;
                8'hC0: nv_prot[b] = nv_prot[b] | (c == 8'h00);
                8'h50: lock_bit = 1'b0;
                8'hE0: vol_prot[b] = (c == 8'h00);
                default: ;
            endcase
            // clear refused while lock bit is 0
            7: nv_prot = (c == 8'h30 && lock_bit) ? '0 : nv_prot;
            8: stp = (c == 8'h03) ? 9 : 0;
            9, 10, 11, 12: ok = ok & (w == pwd[stp - 9]) & (a[1:0] == 2'(stp - 9));
            13: lock_bit = (c == 8'h29 && ok) ? 1'b1 : lock_bit;
            default: ;
        endcase
        // Advance from the step this cycle was decoded in
        if (s0 >= 9 && s0 <= 12) stp = s0 + 1;
        else if (s0 == 8) ok = 1'b1;
        // anything else returns to the first cycle
        else if (s0 > 1) stp = 0;
    endtask
    always @(posedge clk_sys) begin
        prev_we <= pins.we_n;
        if (!pins.ce_n && !pins.oe_n) last <= dq;
        if (!prev_we && pins.we_n && !pins.ce_n) wcyc(pins.addr, pins.dq_o);
    end
    // Released bus shows the inverse of the last value
    always_comb dq = (!pins.ce_n && !pins.oe_n) ? rval(pins.addr) : ~last;
endmodule

// file: test/tb.sv
// Self-checking bench for the block protection controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata, d;
    logic [15:0] flash_dq_i;
    bpc_pkg::bpc_pins_t flash_pins;
    int err_count = 0;
    int checks = 0;
    int t;
    logic [15:0] pw [4] = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081};
    logic [7:0] codes [6] = '{8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0, 8'h88};
    always #4 clk_sys = ~clk_sys;
    bpc_host u_bpc_host (.clk_sys(clk_sys), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_pins(flash_pins),
        .flash_dq_i(flash_dq_i));
    bpc_flash_model u_bpc_flash_model (.clk_sys(clk_sys), .pins(flash_pins), .dq(flash_dq_i));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Runs one operation and checks its error flag
    task automatic op(input logic [2:0] o, input logic [22:0] a, input logic [15:0] v,
        input logic e);
        wr(8'h04, {9'h000, a});
        wr(8'h08, {16'h0000, v});
        wr(8'h00, {29'h0, o});
        t = 0;
        do begin
            rd(8'h00);
            t++;
        end while (d[0] !== 1'b0 && t < 500);
        chk({d[2], d[1]}, {e, 1'b1});
    endtask
    task automatic fr(input logic [22:0] a, input logic [15:0] x);
        op(3'h3, a, 16'h0000, 1'b0);
        rd(8'h0C);
        chk(d, {16'h0000, x});
    endtask
    task automatic endt(input string s);
        $display("test %s finished", s);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h10);
        chk(d, 32'h0000FFFF);
        rd(8'h20);
        chk(d, 32'h0);
        op(3'h1, 23'h0, 16'h0000, 1'b1);
        endt("reset");
        foreach (codes[i]) begin
            op(3'h0, 23'h400000, {8'h00, codes[i]}, 1'b0);
            rd(8'h00);
            chk(d[15:8], codes[i]);
            op(3'h0, 23'h0, 16'h00C0, 1'b1);
            op(3'h1, 23'h0, 16'h0000, 1'b0);
            rd(8'h00);
            chk(d[3], 1'b0);
        end
        endt("sets");
        op(3'h0, 23'h400000, 16'h00C0, 1'b0);
        op(3'h2, 23'h024000, 16'h0000, 1'b0);
        fr(23'h0240A0, 16'h0000);
        fr(23'h034000, 16'h0001);
        op(3'h4, 23'h0, 16'h0000, 1'b0);
        fr(23'h0240A0, 16'h0001);
        op(3'h1, 23'h0, 16'h0000, 1'b0);
        op(3'h4, 23'h0, 16'h0000, 1'b1);
        endt("nonvolatile");
        op(3'h0, 23'h400000, 16'h00E0, 1'b0);
        for (int v = 0; v < 2; v++) begin
            op(3'h2, 23'h035000, v[15:0], 1'b0);
            fr(23'h035002, v[15:0]);
        end
        op(3'h1, 23'h0, 16'h0000, 1'b0);
        op(3'h0, 23'h0, 16'h0040, 1'b0);
        op(3'h2, 23'h0, 16'hC3A5, 1'b0);
        fr(23'h0, 16'hC3A5);
        op(3'h1, 23'h0, 16'h0000, 1'b0);
        op(3'h0, 23'h0, 16'h0050, 1'b0);
        fr(23'h400000, 16'h0001);
        op(3'h2, 23'h0, 16'h0000, 1'b0);
        fr(23'h400000, 16'h0000);
        op(3'h1, 23'h0, 16'h0000, 1'b0);
        endt("volatile lock");
        op(3'h0, 23'h0, 16'h0060, 1'b0);
        for (int n = 3; n >= 0; n--) begin
            op(3'h2, n[22:0], pw[n], 1'b0);
            wr(8'h10 | {4'h0, n[1:0], 2'b00}, {16'h0000, pw[n]});
        end
        fr(23'h000002, pw[2]);
        op(3'h5, 23'h0, 16'h0000, 1'b0);
        chk(t >= 90, 1'b1);
        op(3'h1, 23'h0, 16'h0000, 1'b0);
        op(3'h0, 23'h0, 16'h0050, 1'b0);
        fr(23'h400000, 16'h0001);
        endt("password");
        finish_test();
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        err_count++;
        finish_test();
    end
endmodule
bind bpc_host bpc_host_properties u_bpc_host_properties (.clk_sys(clk_sys), .rst(rst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .flash_pins(flash_pins), .flash_dq_i(flash_dq_i));
